/* File: core/ddc_regs.svh */
// ddc_regs.svh: constants for the dual dma program and idle control
// assumes inclusion by bare name from the dma control module only
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH
// decoder ranges, 10-bit i/o address, low and high bound
`define DDC_BYTE_DMA_LO 10'h000
`define DDC_BYTE_DMA_HI 10'h00f
`define DDC_INTR1_LO 10'h020
`define DDC_INTR1_HI 10'h021
`define DDC_CFG_LO 10'h022
`define DDC_CFG_HI 10'h023
`define DDC_CTC_LO 10'h040
`define DDC_CTC_HI 10'h043
`define DDC_PAGE_LO 10'h080
`define DDC_PAGE_HI 10'h08f
`define DDC_INTR2_LO 10'h0a0
`define DDC_INTR2_HI 10'h0a1
`define DDC_WORD_DMA_LO 10'h0c0
`define DDC_WORD_DMA_HI 10'h0df
// register indices inside a dma unit (after address shift)
`define DDC_IDX_STATUS_CMD 4'h8
`define DDC_IDX_REQUEST 4'h9
`define DDC_IDX_CMDRD_MASK1 4'ha
`define DDC_IDX_MODE 4'hb
`define DDC_IDX_POINTER 4'hc
`define DDC_IDX_TEMP_MCLR 4'hd
`define DDC_IDX_CLRMASK 4'he
`define DDC_IDX_ALLMASK 4'hf
// field positions
`define DDC_CMD_DISABLE_BIT 2
`define DDC_SETBIT_BIT 2
// reset values
`define DDC_MASK_RESET 4'hf
`define DDC_CMD_RESET 8'h00
// address sync reset value, outside every decoder range
`define DDC_ADDR_PARK 10'h3ff
`endif

/* File: core/ddc_pkg.sv */
// ddc_pkg: types shared by the dual dma program and idle control
// assumes ddc_regs.svh is on the include path
package ddc_pkg;
   // unit operating mode
   typedef enum logic [1:0] {DDC_IDLE, DDC_PROGRAM, DDC_ACTIVE} ddc_mode_e;
   // one select per internal subsystem
   typedef struct packed {
      logic byteDma; // byte-wide dma unit
      logic firstIntr; // first interrupt unit
      logic cfgReg; // configuration register pair
      logic counterTimer; // counter/timer unit
      logic dma_page_regs; // dma page registers
      logic secondIntr; // second interrupt unit
      logic wordDma; // word-wide dma unit
   } ddc_sel_s;
   // one decoded register access
   typedef struct packed {
      logic unit; // 0 byte unit, 1 word unit
      logic [3:0] idx; // register index inside the unit
   } ddc_acc_s;
endpackage

/* File: core/ddc_dma_ctrl.sv */
// ddc_dma_ctrl: decoder, program access and idle/active control of two
// cascaded four-channel dma units
// assumes all pins but rst and clkEn are asynchronous to core_clk and are synchronised here
// Notes on behaviour
// - decoder gives seven separate subsystem selects
// - two four-channel units, word channel 0 cascades
// - idle mode performs no transfers
// - idle samples requests, select, hold-acknowledge each cycle
// - active only when initialized and request present
// - program mode when no hold-ack and selected
// - program mode wins over active mode
// - byte unit uses A[3:0], word A[4:1]
// - word unit ignores address bit 0
// - read/write strobes time accesses in program mode
// - byte pointer picks high or low byte
// - pointer cleared by reset and master clear
// - set/clear pointer commands move the pointer
// - special commands ignore the data bus
// - active on software or unmasked programmed request
// - pointer 0 low byte, 1 high byte
`include "ddc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ddc_dma_ctrl
   import ddc_pkg::*;
(
   input wire logic core_clk, // 40 mhz peripheral clock
   input wire logic rst, // async reset, active high
   input wire logic clkEn, // freezes all state when low
   input wire logic [9:0] ioAddr, // i/o address pins
   input wire logic [7:0] ioDataIn, // i/o data bus in
   input wire logic ioReadStrobeN, // i/o read strobe, low active
   input wire logic ioWriteStrobeN, // i/o write strobe, low active
   input wire logic holdAcknowledge, // bus hold acknowledge
   input wire logic [6:0] periphRequest, // [3:0] byte, [6:4] word ch1-3
   output ddc_sel_s ioSelect, // registered subsystem selects
   output ddc_mode_e byteUnitMode, // byte unit mode
   output ddc_mode_e wordUnitMode, // word unit mode
   output logic [7:0] readData, // register read data
   output logic readDataEn, // drive enable for read data
   output logic [1:0] bytePtr // pointer per unit, [1] word
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [9:0] addrS1, addrS2; // address sync stages
   logic [7:0] dataS1, dataS2; // data sync stages
   logic rdS1, rdS2, rdPrev; // read strobe sync and history
   logic wrS1, wrS2, wrPrev; // write strobe sync and history
   logic hldaS1, hldaS2; // hold-acknowledge sync
   logic [6:0] reqS1, reqS2; // request sync
   // two flops on every pin, a third on each strobe; logic reads stage 2 and the strobe history flops
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addrS1 <= `DDC_ADDR_PARK; // no false select after reset
         addrS2 <= `DDC_ADDR_PARK;
         dataS1 <= 8'h00;
         dataS2 <= 8'h00;
         rdS1 <= 1'b1;
         rdS2 <= 1'b1;
         rdPrev <= 1'b1;
         wrS1 <= 1'b1;
         wrS2 <= 1'b1;
         wrPrev <= 1'b1;
         hldaS1 <= 1'b0;
         hldaS2 <= 1'b0;
         reqS1 <= 7'h00;
         reqS2 <= 7'h00;
      end else if (clkEn) begin
         addrS1 <= ioAddr;
         addrS2 <= addrS1;
         dataS1 <= ioDataIn;
         dataS2 <= dataS1;
         rdS1 <= ioReadStrobeN;
         rdS2 <= rdS1;
         rdPrev <= rdS2;
         wrS1 <= ioWriteStrobeN;
         wrS2 <= wrS1;
         wrPrev <= wrS2;
         hldaS1 <= holdAcknowledge;
         hldaS2 <= hldaS1;
         reqS1 <= periphRequest;
         reqS2 <= reqS1;
      end
   end

   // ---------------------------------------------------------------
   // top level decoder
   // ---------------------------------------------------------------
   ddc_sel_s selNow; // decode of current address
   ddc_acc_s acc; // unit and register index
   logic rdStart, wrStart; // strobe assertion edges
   always_comb begin
      // separate range compares per subsystem
      selNow.byteDma = addrS2 <= `DDC_BYTE_DMA_HI;
      selNow.firstIntr = addrS2 >= `DDC_INTR1_LO &&
         addrS2 <= `DDC_INTR1_HI;
      selNow.cfgReg = addrS2 >= `DDC_CFG_LO &&
         addrS2 <= `DDC_CFG_HI;
      selNow.counterTimer = addrS2 >= `DDC_CTC_LO &&
         addrS2 <= `DDC_CTC_HI;
      selNow.dma_page_regs = addrS2 >= `DDC_PAGE_LO &&
         addrS2 <= `DDC_PAGE_HI;
      selNow.secondIntr = addrS2 >= `DDC_INTR2_LO &&
         addrS2 <= `DDC_INTR2_HI;
      selNow.wordDma = addrS2 >= `DDC_WORD_DMA_LO &&
         addrS2 <= `DDC_WORD_DMA_HI;
      // unit register select, bit 0 dropped for the word unit
      acc.unit = selNow.wordDma;
      acc.idx = selNow.wordDma ? addrS2[4:1] : addrS2[3:0];
      rdStart = rdPrev && !rdS2;
      wrStart = wrPrev && !wrS2;
   end

   // ---------------------------------------------------------------
   // mode control, one machine per unit
   // ---------------------------------------------------------------
   ddc_mode_e modeReg [2]; // per unit mode
   ddc_mode_e modeNext [2];
   logic [1:0] unitSel; // unit selects
   logic [1:0] progCond; // program entry condition per unit
   logic [1:0] reqCond; // active entry condition per unit
   logic [3:0] reqVec [2]; // hardware requests per unit
   logic [7:0] cmdReg [2], cmdNext [2]; // command register
   logic [3:0] maskReg [2], maskNext [2]; // request masks
   logic [3:0] swReqReg [2], swReqNext [2]; // software requests
   logic [1:0] initReg, initNext; // unit initialised
   logic [7:0] progReg, progNext; // channel programmed
   assign unitSel = {selNow.wordDma, selNow.byteDma};
   // word channel 0 is the cascade link from the byte unit
   assign reqVec[0] = reqS2[3:0];
   assign reqVec[1] = {reqS2[6:4], modeReg[0] == DDC_ACTIVE};
   genvar u;
   generate
      for (u = 0; u < 2; u++) begin : gUnit
         // entry conditions, sampled every cycle
         always_comb begin
            progCond[u] = !hldaS2 && unitSel[u];
            reqCond[u] = initReg[u] &&
               !cmdReg[u][`DDC_CMD_DISABLE_BIT] &&
               ((|(reqVec[u] & ~maskReg[u] &
               progReg[4*u +: 4])) || (|swReqReg[u]));
         end
         // next mode; program outranks active
         always_comb begin
            modeNext[u] = modeReg[u];
            unique case (modeReg[u])
               DDC_IDLE: begin
                  // repeated idle states, no transfer
                  if (progCond[u]) begin
                     modeNext[u] = DDC_PROGRAM;
                  end else if (reqCond[u]) begin
                     modeNext[u] = DDC_ACTIVE;
                  end else begin
                     modeNext[u] = DDC_IDLE;
                  end
               end
               DDC_PROGRAM, DDC_ACTIVE: begin
                  // a selected unit goes to program, even from active
                  if (progCond[u]) begin
                     modeNext[u] = DDC_PROGRAM;
                  end else begin
                     modeNext[u] = reqCond[u] ? DDC_ACTIVE : DDC_IDLE;
                  end
               end
            endcase
         end
         // mode register
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               modeReg[u] <= DDC_IDLE;
            end else if (clkEn) begin
               modeReg[u] <= modeNext[u];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // program mode register access
   // ---------------------------------------------------------------
   logic [15:0] addrReg [8], addrNext [8]; // channel address
   logic [15:0] cntReg [8], cntNext [8]; // channel word count
   logic [5:0] chModeReg [8], chModeNext [8]; // channel mode
   logic [1:0] ptrReg, ptrNext; // byte pointer per unit
   logic [7:0] rdNext; // read data next
   logic rdEnNext; // read enable next
   logic doRd, doWr; // qualified access edges
   logic [2:0] ch; // global channel index
   logic u1; // accessed unit
   always_comb begin
      u1 = acc.unit;
      ch = {u1, acc.idx[2:1]};
      doRd = rdStart && progCond[u1];
      doWr = wrStart && progCond[u1];
      addrNext = addrReg;
      cntNext = cntReg;
      chModeNext = chModeReg;
      ptrNext = ptrReg;
      cmdNext = cmdReg;
      maskNext = maskReg;
      swReqNext = swReqReg;
      initNext = initReg;
      progNext = progReg;
      rdNext = readData;
      rdEnNext = !rdS2 && progCond[u1];
      if (doRd || doWr) begin
         if (!acc.idx[3]) begin
            // 16-bit address or count, one byte at a time
            if (doWr && acc.idx[0]) begin
               if (ptrReg[u1]) begin
                  cntNext[ch][15:8] = dataS2;
                  progNext[ch] = 1'b1;
               end else begin
                  cntNext[ch][7:0] = dataS2;
               end
            end else if (doWr) begin
               if (ptrReg[u1]) begin
                  addrNext[ch][15:8] = dataS2;
               end else begin
                  addrNext[ch][7:0] = dataS2;
               end
            end else if (acc.idx[0]) begin
               rdNext = ptrReg[u1] ? cntReg[ch][15:8] :
                  cntReg[ch][7:0];
            end else begin
               rdNext = ptrReg[u1] ? addrReg[ch][15:8] :
                  addrReg[ch][7:0];
            end
            ptrNext[u1] = !ptrReg[u1];
         end else begin
            unique case (acc.idx)
               `DDC_IDX_STATUS_CMD: begin
                  if (doWr) begin
                     cmdNext[u1] = dataS2;
                     initNext[u1] = 1'b1;
                  end else begin
                     rdNext = {reqVec[u1], 4'h0};
                  end
               end
               `DDC_IDX_REQUEST: begin
                  if (doWr) begin
                     swReqNext[u1][dataS2[1:0]] =
                        dataS2[`DDC_SETBIT_BIT];
                  end else begin
                     rdNext = {4'h0, swReqReg[u1]};
                  end
               end
               `DDC_IDX_CMDRD_MASK1: begin
                  if (doWr) begin
                     maskNext[u1][dataS2[1:0]] =
                        dataS2[`DDC_SETBIT_BIT];
                  end else begin
                     rdNext = cmdReg[u1];
                  end
               end
               `DDC_IDX_MODE: begin
                  if (doWr) begin
                     chModeNext[{u1, dataS2[1:0]}] = dataS2[7:2];
                  end else begin
                     rdNext = {chModeReg[ch], 2'h0};
                  end
               end
               `DDC_IDX_POINTER: begin
                  // read sets, write clears; data unused
                  ptrNext[u1] = doRd;
               end
               `DDC_IDX_TEMP_MCLR: begin
                  if (doWr) begin
                     // master clear, data unused
                     ptrNext[u1] = 1'b0;
                     cmdNext[u1] = `DDC_CMD_RESET;
                     maskNext[u1] = `DDC_MASK_RESET;
                     swReqNext[u1] = 4'h0;
                     initNext[u1] = 1'b0;
                  end else begin
                     rdNext = 8'h00;
                  end
               end
               `DDC_IDX_CLRMASK: begin
                  if (doWr) begin
                     maskNext[u1] = 4'h0;
                  end
               end
               `DDC_IDX_ALLMASK: begin
                  if (doWr) begin
                     maskNext[u1] = dataS2[3:0];
                  end else begin
                     rdNext = {4'hf, maskReg[u1]};
                  end
               end
            endcase
         end
      end
   end
   // access state registers; pointer cleared by reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            addrReg[i] <= 16'h0000;
            cntReg[i] <= 16'h0000;
            chModeReg[i] <= 6'h00;
         end
         for (int j = 0; j < 2; j++) begin
            cmdReg[j] <= `DDC_CMD_RESET;
            maskReg[j] <= `DDC_MASK_RESET;
            swReqReg[j] <= 4'h0;
         end
         ptrReg <= 2'b00;
         initReg <= 2'b00;
         progReg <= 8'h00;
         readData <= 8'h00;
         readDataEn <= 1'b0;
         ioSelect <= '0;
      end else if (clkEn) begin
         addrReg <= addrNext;
         cntReg <= cntNext;
         chModeReg <= chModeNext;
         cmdReg <= cmdNext;
         maskReg <= maskNext;
         swReqReg <= swReqNext;
         ptrReg <= ptrNext;
         initReg <= initNext;
         progReg <= progNext;
         readData <= rdNext;
         readDataEn <= rdEnNext;
         ioSelect <= selNow;
      end
   end
   // ---------------------------------------------------------------
   // outputs straight from flops
   // ---------------------------------------------------------------
   assign byteUnitMode = modeReg[0];
   assign wordUnitMode = modeReg[1];
   assign bytePtr = ptrReg;
endmodule
`default_nettype wire

/* File: verif/ddc_dma_ctrl_properties.sv */
// ddc_dma_ctrl_properties: port checks of the dma program control
// assumes bound to ddc_dma_ctrl; pins reach outputs three edges later
`timescale 1ns/1ps
`default_nettype none
module ddc_dma_ctrl_properties
   import ddc_pkg::*;
(
   input wire logic core_clk, // peripheral clock
   input wire logic rst, // async reset
   input wire logic [9:0] ioAddr, // address pins
   input wire logic ioReadStrobeN, // read strobe
   input wire logic ioWriteStrobeN, // write strobe
   input wire logic holdAcknowledge, // hold ack
   input wire ddc_sel_s ioSelect, // selects
   input wire ddc_mode_e byteUnitMode, // byte mode
   input wire ddc_mode_e wordUnitMode, // word mode
   input wire logic [7:0] readData, // read data
   input wire logic readDataEn, // read enable
   input wire logic [1:0] bytePtr // pointers
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic inByte; // byte unit range
   logic inWord; // word unit range
   ddc_sel_s expSel; // expected decode
   assign inByte = ioAddr <= 10'h00f;
   assign inWord = ioAddr inside {[10'h0c0:10'h0df]};
   assign expSel = '{inByte, ioAddr inside {[10'h020:10'h021]},
      ioAddr inside {[10'h022:10'h023]}, ioAddr inside {[10'h040:10'h043]},
      ioAddr inside {[10'h080:10'h08f]}, ioAddr inside {[10'h0a0:10'h0a1]},
      inWord};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_select_decode: assert property (
      $stable(ioAddr)[*4] |-> ioSelect == expSel)
      else $error("select does not match address");
   a_prog_byte: assert property (
      (!holdAcknowledge && inByte)[*4] |-> byteUnitMode == DDC_PROGRAM)
      else $error("byte unit missed program mode");
   a_prog_word: assert property (
      (!holdAcknowledge && inWord)[*4] |-> wordUnitMode == DDC_PROGRAM)
      else $error("word unit missed program mode");
   a_hold_blocks: assert property (
      holdAcknowledge[*4] |-> byteUnitMode != DDC_PROGRAM &&
      wordUnitMode != DDC_PROGRAM)
      else $error("program mode under hold");
   a_rden_on: assert property (
      (!ioReadStrobeN && !holdAcknowledge && (inByte || inWord))[*4]
      |-> readDataEn)
      else $error("read enable missing");
   a_rden_off: assert property (
      ioReadStrobeN[*4] |-> !readDataEn)
      else $error("read enable without strobe");
   a_rdata_hold: assert property (
      ioReadStrobeN[*4] |=> $stable(readData))
      else $error("read data moved without read");
   a_ptr_quiet: assert property (
      (ioReadStrobeN && ioWriteStrobeN)[*4] |=> $stable(bytePtr))
      else $error("pointer moved without access");
endmodule
bind ddc_dma_ctrl ddc_dma_ctrl_properties i_props (
   .core_clk(core_clk), .rst(rst), .ioAddr(ioAddr),
   .ioReadStrobeN(ioReadStrobeN), .ioWriteStrobeN(ioWriteStrobeN),
   .holdAcknowledge(holdAcknowledge), .ioSelect(ioSelect),
   .byteUnitMode(byteUnitMode), .wordUnitMode(wordUnitMode),
   .readData(readData), .readDataEn(readDataEn), .bytePtr(bytePtr));
`default_nettype wire

/* File: verif/ddc_host_model.sv */
// ddc_host_model: processor side issuing i/o register cycles
// assumes core_clk from the bench; pins change on falling edges only
`timescale 1ns/1ps
`default_nettype none
module ddc_host_model (
   input wire logic core_clk, // bench clock
   input wire logic [7:0] readData, // read data from block
   input wire logic readDataEn, // read data valid
   output logic [9:0] ioAddr, // address pins
   output logic [7:0] ioDataIn, // write data pins
   output logic ioReadStrobeN, // read strobe, low active
   output logic ioWriteStrobeN, // write strobe, low active
   output logic holdAcknowledge // bus hold acknowledge
);
   initial begin
      ioAddr = 10'h3ff;
      ioDataIn = 8'hff;
      ioReadStrobeN = 1'b1;
      ioWriteStrobeN = 1'b1;
      holdAcknowledge = 1'b0;
   end
   // hold acknowledge level, settled before returning
   task automatic hold(input logic v);
      @(negedge core_clk);
      holdAcknowledge = v;
      repeat (4) @(negedge core_clk);
   endtask
   // address parked with no strobe
   task automatic park(input logic [9:0] a);
      @(negedge core_clk);
      ioAddr = a;
      repeat (4) @(negedge core_clk);
   endtask
   // one strobe cycle; released pins show the inverse value
   task automatic cyc(input logic [9:0] a, input logic [7:0] d,
                      input logic rd, output logic [7:0] q);
      q = 8'hxx;
      @(negedge core_clk);
      ioAddr = a;
      ioDataIn = d;
      repeat (3) @(negedge core_clk);
      if (rd) ioReadStrobeN = 1'b0;
      else ioWriteStrobeN = 1'b0;
      // sampled at falling edges, away from the launching edge
      repeat (8) begin
         @(negedge core_clk);
         if (rd && readDataEn === 1'b1) q = readData;
      end
      @(negedge core_clk);
      ioReadStrobeN = 1'b1;
      ioWriteStrobeN = 1'b1;
      @(negedge core_clk);
      ioAddr = ~a;
      ioDataIn = ~d;
      repeat (3) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

/* File: verif/tb_dual_dma_program_idle_control.sv */
// tb_dual_dma_program_idle_control: self-checking bench for ddc_dma_ctrl
// assumes ddc_pkg, the host model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module tb_dual_dma_program_idle_control;
   import ddc_pkg::*;
   logic core_clk; // 40 mhz clock
   logic rst; // active high reset
   logic [6:0] periphRequest; // peripheral requests
   logic [9:0] ioAddr; // host address
   logic [7:0] ioDataIn; // host data
   logic ioReadStrobeN; // host read strobe
   logic ioWriteStrobeN; // host write strobe
   logic holdAcknowledge; // host hold ack
   ddc_sel_s ioSelect; // selects
   ddc_mode_e byteUnitMode; // byte mode
   ddc_mode_e wordUnitMode; // word mode
   logic [7:0] readData; // read data
   logic readDataEn; // read enable
   logic [1:0] bytePtr; // pointers
   int failures = 0; // mismatches
   int numChecks = 0; // comparisons
   int cycles = 0; // timeout count
   ddc_dma_ctrl i_dut (
      .core_clk(core_clk), .rst(rst), .clkEn(1'b1), .ioAddr(ioAddr),
      .ioDataIn(ioDataIn), .ioReadStrobeN(ioReadStrobeN),
      .ioWriteStrobeN(ioWriteStrobeN), .holdAcknowledge(holdAcknowledge),
      .periphRequest(periphRequest), .ioSelect(ioSelect),
      .byteUnitMode(byteUnitMode), .wordUnitMode(wordUnitMode),
      .readData(readData), .readDataEn(readDataEn), .bytePtr(bytePtr));
   ddc_host_model i_host (
      .core_clk(core_clk), .readData(readData), .readDataEn(readDataEn),
      .ioAddr(ioAddr), .ioDataIn(ioDataIn), .ioReadStrobeN(ioReadStrobeN),
      .ioWriteStrobeN(ioWriteStrobeN), .holdAcknowledge(holdAcknowledge));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp,
                        input string msg);
      numChecks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got,
                  exp);
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [7:0] q;
      i_host.cyc(a, d, 1'b0, q);
   endtask
   task automatic rdc(input logic [9:0] a, input logic [7:0] e, string m);
      logic [7:0] q;
      i_host.cyc(a, 8'h5a, 1'b1, q);
      check(q, e, m);
   endtask
   // requests applied, then byte mode judged and word unit checked idle
   task automatic reqs(input logic [6:0] r, input ddc_mode_e m, string s);
      @(negedge core_clk);
      periphRequest = r;
      repeat (5) @(negedge core_clk);
      check(8'(byteUnitMode), 8'(m), s);
      check(8'(wordUnitMode), 8'(DDC_IDLE), "word unit idle");
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      check(8'(ioSelect), 8'h00, "select in reset");
      check(8'(byteUnitMode), 8'(DDC_IDLE), "mode in reset");
      check(8'(bytePtr), 8'h00, "pointer in reset");
      check(8'(readDataEn), 8'h00, "read enable in reset");
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      check(8'(ioSelect), 8'h00, "select after release");
      check(8'(byteUnitMode), 8'(DDC_IDLE), "idle after release");
      $display("test reset done");
   endtask
   task automatic t_decode();
      logic [9:0] adr [10] = '{10'h00f, 10'h010, 10'h021, 10'h022,
         10'h043, 10'h08f, 10'h0a1, 10'h0df, 10'h0e0, 10'h024};
      logic [6:0] sel [10] = '{7'h40, 7'h00, 7'h20, 7'h10, 7'h08, 7'h04,
         7'h02, 7'h01, 7'h00, 7'h00};
      for (int i = 0; i < 10; i++) begin
         i_host.park(adr[i]);
         check(8'(ioSelect), 8'(sel[i]), "decoder select");
         check(8'({wordUnitMode == DDC_PROGRAM, byteUnitMode == DDC_PROGRAM}),
               8'({sel[i][0], sel[i][6]}), "program on select");
      end
      $display("test decode done");
   endtask
   task automatic t_pointer();
      wr(10'h000, 8'h34);
      check(8'(bytePtr), 8'h01, "pointer toggled");
      wr(10'h000, 8'h12);
      rdc(10'h000, 8'h34, "address low");
      rdc(10'h000, 8'h12, "address high");
      wr(10'h0c1, 8'h56);
      wr(10'h0c0, 8'h78);
      check(8'(bytePtr), 8'h00, "word pointer back");
      rdc(10'h0c0, 8'h56, "word low");
      rdc(10'h0c1, 8'h78, "word high");
      $display("test pointer done");
   endtask
   task automatic t_cmds();
      logic [7:0] q;
      i_host.cyc(10'h00c, 8'h00, 1'b1, q);
      check(8'(bytePtr), 8'h01, "set pointer");
      wr(10'h00c, 8'hff);
      check(8'(bytePtr), 8'h00, "clear pointer");
      i_host.cyc(10'h0d9, 8'h00, 1'b1, q);
      check(8'(bytePtr), 8'h02, "word set pointer");
      wr(10'h0c0, 8'h00);
      check(8'(bytePtr), 8'h00, "word set then toggle");
      wr(10'h0c0, 8'h00);
      wr(10'h0db, 8'ha5);
      check(8'(bytePtr), 8'h00, "master clear");
      i_host.hold(1'b1);
      wr(10'h000, 8'h77);
      check(8'(bytePtr), 8'h00, "access refused under hold");
      i_host.hold(1'b0);
      $display("test commands done");
   endtask
   task automatic t_active();
      wr(10'h00f, 8'h0f);
      wr(10'h001, 8'h10);
      wr(10'h001, 8'h00);
      wr(10'h00b, 8'h00);
      wr(10'h008, 8'h00);
      reqs(7'h71, DDC_IDLE, "masked request");
      wr(10'h00a, 8'h00);
      reqs(7'h71, DDC_ACTIVE, "active on request");
      i_host.park(10'h008);
      check(8'(byteUnitMode), 8'(DDC_PROGRAM), "program first");
      i_host.park(10'h3ff);
      wr(10'h008, 8'h04);
      reqs(7'h01, DDC_IDLE, "disabled unit");
      wr(10'h008, 8'h00);
      reqs(7'h00, DDC_IDLE, "idle without request");
      wr(10'h009, 8'h04);
      reqs(7'h00, DDC_ACTIVE, "software request");
      wr(10'h00d, 8'h00);
      reqs(7'h01, DDC_IDLE, "master clear idles");
      $display("test active done");
   endtask
   // word channel 0 follows the byte unit through the cascade link
   task automatic t_cascade();
      wr(10'h0c2, 8'h00);
      wr(10'h0c2, 8'h01);
      wr(10'h0dc, 8'h00);
      wr(10'h0d0, 8'h00);
      wr(10'h00e, 8'h00);
      wr(10'h008, 8'h00);
      reqs(7'h00, DDC_IDLE, "cascade idle");
      @(negedge core_clk);
      periphRequest = 7'h01;
      repeat (5) @(negedge core_clk);
      check(8'(wordUnitMode), 8'(DDC_ACTIVE), "cascade active");
      @(negedge core_clk);
      periphRequest = 7'h00;
      repeat (5) @(negedge core_clk);
      check(8'(wordUnitMode), 8'(DDC_IDLE), "cascade released");
      $display("test cascade done");
   endtask
   // ----------------------------------------
   // clock, timeout, sequence
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         $display("CHECK FAILED at %0t: timeout", $time);
         results();
      end
   end
   initial begin
      rst = 1'b1;
      periphRequest = 7'h00;
      repeat (10) @(negedge core_clk);
      t_reset();
      t_decode();
      t_pointer();
      t_cmds();
      t_active();
      t_cascade();
      results();
   end
endmodule
`default_nettype wire
